/* File: dbt_engine.sv */
// The placing of the registers and strobed register access were decided locally.
`include "dbt_map.svh"
module dbt_engine
   import dbt_pkg::*;
#(
   parameter logic [18:0] TICK_CYCLES = 19'(`DBT_TICK_CYCLES)
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        svc_req,
   input  wire logic        svc_top,
   input  wire logic        instr_done,
   input  wire logic [4:0]  svc_station,
   output logic      [15:0] mem_addr,
   output logic      [15:0] mem_wdata,
   output logic             mem_re,
   output logic             mem_we,
   output logic             mem_lock,
   input  wire logic [15:0] mem_rdata,
   output logic             io_req,
   output logic             io_write,
   output logic      [3:0]  io_equip,
   output logic      [6:0]  io_station,
   output logic      [15:0] io_wdata,
   input  wire logic        io_ack,
   input  wire logic        io_err,
   input  wire logic [15:0] io_rdata,
   output logic             macro_irq,
   output logic             clk_irq
);
   dbt_core_t  q;
   dbt_core_t  d;
   dbt_tick_if tk_if ();

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [15:0] f_entry(logic [15:0] base, dbt_kind_t k, logic [4:0] s);
      logic [15:0] ofs;
      ofs = {9'h000, s, 2'b00};
      case (k)
         DBT_K_MULTI: f_entry = base + ofs + `DBT_ENTRY_WORDS;
         DBT_K_PORT:  f_entry = base + ofs;
         default:     f_entry = base;
      endcase
   endfunction

   function automatic logic [15:0] f_out_item(logic [15:0] w, logic ch, logic second);
      if (!ch) begin
         f_out_item = w;
      end else if (!second) begin
         f_out_item = {8'h00, w[15:8]};
      end else begin
         f_out_item = {8'h00, w[7:0]};
      end
   endfunction

   function automatic logic [15:0] f_in_merge(logic [15:0] old, logic [15:0] item,
                                              logic ch, logic second);
      if (!ch) begin
         f_in_merge = item;
      end else if (!second) begin
         f_in_merge = {item[7:0], 8'h00};
      end else begin
         f_in_merge = {old[15:8], item[7:0]};
      end
   endfunction

   dbt_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .tk      (tk_if.gen)
   );
   assign tk_if.en = q.ctrl[`DBT_CTRL_CLKEN];

   logic        ch;
   logic        second;
   logic        is_out;
   logic [15:0] nxt;
   logic        in_range;
   dbt_kind_t   hk;

   assign ch     = q.w1[`DBT_W1_CHAR];
   assign second = q.phase[q.sta];
   assign is_out = q.w1[`DBT_W1_DIR];
   assign nxt    = q.cur_addr + 16'h0001;

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      d = q;
      d.mem_re    = 1'b0;
      d.mem_we    = 1'b0;
      d.mem_lock  = 1'b0;
      d.io_req    = 1'b0;
      d.macro_irq = 1'b0;
      d.clk_irq   = 1'b0;
      d.rdata     = 16'h0000;
      hk = DBT_K_SINGLE;
      in_range = 1'b1;
      if (mem_rdata[`DBT_W1_PORT] && !mem_rdata[`DBT_W1_MULTI]) begin
         hk = DBT_K_PORT;
         in_range = q.sta <= {2'b00, mem_rdata[`DBT_MAXPOS_HI:`DBT_MAX_LO]};
      end else if (mem_rdata[`DBT_W1_MULTI]) begin
         hk = DBT_K_MULTI;
         in_range = q.sta <= mem_rdata[`DBT_MAXST_HI:`DBT_MAX_LO];
      end

      if (reg_rd) begin
         case (reg_addr)
            `DBT_REG_CTRL:  d.rdata = {13'h0000, q.ctrl};
            `DBT_REG_BASE:  d.rdata = q.base;
            `DBT_REG_CBASE: d.rdata = q.cbase;
            `DBT_REG_STAT:  d.rdata = {12'h000, q.st != DBT_S_IDLE, q.chit, q.err, q.done};
            default:        d.rdata = 16'h0000;
         endcase
      end
      if (reg_wr) begin
         case (reg_addr)
            `DBT_REG_CTRL:  d.ctrl = reg_wdata[2:0];
            `DBT_REG_BASE: begin
               d.base  = reg_wdata;
               d.phase = 32'h00000000;
            end
            `DBT_REG_CBASE: d.cbase = reg_wdata;
            `DBT_REG_STAT: begin
               d.done = q.done & ~reg_wdata[`DBT_STAT_DONE];
               d.err  = q.err  & ~reg_wdata[`DBT_STAT_ERR];
               d.chit = q.chit & ~reg_wdata[`DBT_STAT_CHIT];
            end
            default: ;
         endcase
      end

      // Ticks accumulate into one pending request; set beats clear below
      if (tk_if.tick) begin
         d.tick_pend = 1'b1;
      end

      case (q.st)
         DBT_S_IDLE: begin
            if (q.tick_pend && q.ctrl[`DBT_CTRL_CLKEN]) begin
               d.tick_pend = tk_if.tick;
               d.mem_re    = 1'b1;
               d.mem_addr  = q.cbase + `DBT_OFS_CUR;
               d.st        = DBT_S_CW2;
            end else if (q.ctrl[`DBT_CTRL_ARM] && svc_req && svc_top && instr_done) begin
               d.sta      = svc_station;
               d.mem_re   = 1'b1;
               d.mem_addr = q.base;
               d.st       = DBT_S_HDR;
            end
         end
         DBT_S_HDR: begin
            d.kind = hk;
            if (!in_range) begin
               d.st = DBT_S_IDLE;
            end else begin
               d.ent      = f_entry(q.base, hk, q.sta);
               d.mem_re   = 1'b1;
               d.mem_addr = f_entry(q.base, hk, q.sta);
               d.st       = DBT_S_W1;
            end
         end
         DBT_S_W1: begin
            d.w1       = mem_rdata;
            d.mem_re   = 1'b1;
            d.mem_addr = q.ent + `DBT_OFS_CUR;
            d.st       = DBT_S_W2;
         end
         DBT_S_W2: begin
            d.cur_addr = mem_rdata;
            d.mem_re   = 1'b1;
            d.mem_addr = q.ent + `DBT_OFS_LAST;
            d.st       = DBT_S_W3;
         end
         DBT_S_W3: begin
            d.last_addr = mem_rdata;
            if (q.cur_addr == mem_rdata) begin
               d.st = DBT_S_IDLE;
            end else if (is_out || (ch && second)) begin
               d.mem_re   = 1'b1;
               d.mem_addr = nxt;
               d.st       = DBT_S_DAT;
            end else begin
               d.io_req     = 1'b1;
               d.io_write   = 1'b0;
               d.io_equip   = q.w1[`DBT_W1_EQ_HI:`DBT_W1_EQ_LO];
               d.io_station = (q.kind == DBT_K_PORT) ? {4'h0, q.sta[2:0]}
                                                     : q.w1[`DBT_W1_ST_HI:0];
               d.st         = DBT_S_IO;
            end
         end
         DBT_S_DAT: begin
            d.dat        = mem_rdata;
            d.io_req     = 1'b1;
            d.io_write   = is_out;
            d.io_equip   = q.w1[`DBT_W1_EQ_HI:`DBT_W1_EQ_LO];
            d.io_station = (q.kind == DBT_K_PORT) ? {4'h0, q.sta[2:0]}
                                                  : q.w1[`DBT_W1_ST_HI:0];
            d.io_wdata   = f_out_item(mem_rdata, ch, second);
            d.st         = DBT_S_IO;
         end
         DBT_S_IO: begin
            if (io_ack) begin
               if (io_err) begin
                  d.err       = 1'b1;
                  d.macro_irq = 1'b1;
                  d.st        = DBT_S_IDLE;
               end else begin
                  if (!is_out) begin
                     d.mem_we    = 1'b1;
                     d.mem_addr  = nxt;
                     d.mem_wdata = f_in_merge(q.dat, io_rdata, ch, second);
                  end
                  d.adv           = !ch || second;
                  d.phase[q.sta]  = ch && !second;
                  d.st            = DBT_S_WB;
               end
            end
         end
         DBT_S_WB: begin
            d.st = DBT_S_IDLE;
            if (q.adv) begin
               d.cur_addr  = nxt;
               d.mem_we    = 1'b1;
               d.mem_addr  = q.ent + `DBT_OFS_CUR;
               d.mem_wdata = nxt;
               if (nxt == q.last_addr) begin
                  d.done      = 1'b1;
                  d.macro_irq = 1'b1;
                  if (q.kind == DBT_K_MULTI) begin
                     d.mem_re   = 1'b1;
                     d.mem_we   = 1'b0;
                     d.mem_lock = 1'b1;
                     d.mem_addr = q.base + `DBT_OFS_FLAG + {15'h0000, q.sta[4]};
                     d.st       = DBT_S_FLR;
                  end
               end
            end
         end
         DBT_S_FLR: begin
            // Position write was deferred here so the flag read goes first
            d.mem_we    = 1'b1;
            d.mem_addr  = q.ent + `DBT_OFS_CUR;
            d.mem_wdata = q.cur_addr;
            d.st        = DBT_S_CW3;
            d.kind      = DBT_K_MULTI;
         end
         DBT_S_CW2: begin
            d.clkcnt   = mem_rdata;
            d.mem_re   = 1'b1;
            d.mem_addr = q.cbase + `DBT_OFS_LAST;
            d.st       = DBT_S_CW3;
            d.kind     = DBT_K_SINGLE;
         end
         DBT_S_CW3: begin
            d.st = DBT_S_IDLE;
            if (q.kind == DBT_K_MULTI) begin
               d.mem_we    = 1'b1;
               d.mem_lock  = 1'b1;
               d.mem_addr  = q.base + `DBT_OFS_FLAG + {15'h0000, q.sta[4]};
               d.mem_wdata = q.dat | (16'h0001 << q.sta[3:0]);
            end else begin
               d.mem_we    = 1'b1;
               d.mem_addr  = q.cbase + `DBT_OFS_CUR;
               d.mem_wdata = q.clkcnt + 16'h0001;
               if (q.clkcnt + 16'h0001 == mem_rdata) begin
                  d.chit    = 1'b1;
                  d.clk_irq = q.ctrl[`DBT_CTRL_CLKIE];
               end
            end
         end
         default: d.st = DBT_S_IDLE;
      endcase
      // Flag read data lands in FLR's cycle; keep it for the locked write
      if (q.st == DBT_S_FLR) begin
         d.dat = mem_rdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata  = q.rdata;
   assign mem_addr   = q.mem_addr;
   assign mem_wdata  = q.mem_wdata;
   assign mem_re     = q.mem_re;
   assign mem_we     = q.mem_we;
   assign mem_lock   = q.mem_lock;
   assign io_req     = q.io_req;
   assign io_write   = q.io_write;
   assign io_equip   = q.io_equip;
   assign io_station = q.io_station;
   assign io_wdata   = q.io_wdata;
   assign macro_irq  = q.macro_irq;
   assign clk_irq    = q.clk_irq;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_accept;
      (q.st == DBT_S_HDR && $past(q.st) == DBT_S_IDLE)
         |-> $past(svc_req && svc_top && instr_done);
   endproperty
   a_accept: assert property (p_accept) else $error("service taken without grant");

   property p_stop_at_last;
      (q.st == DBT_S_W3 && mem_rdata == q.cur_addr) |=> (q.st == DBT_S_IDLE) ##1 !io_req;
   endproperty
   a_stop_at_last: assert property (p_stop_at_last) else $error("transfer past last");

   property p_dir;
      io_req |-> (io_write == q.w1[`DBT_W1_DIR]);
   endproperty
   a_dir: assert property (p_dir) else $error("direction mismatch");

   property p_equip;
      io_req |-> (io_equip == q.w1[`DBT_W1_EQ_HI:`DBT_W1_EQ_LO]);
   endproperty
   a_equip: assert property (p_equip) else $error("equipment mismatch");

   property p_char_out;
      (q.st == DBT_S_DAT && is_out && ch && !second)
         |=> (io_req && io_wdata == {8'h00, $past(mem_rdata[15:8])});
   endproperty
   a_char_out: assert property (p_char_out) else $error("first char not upper byte");

   property p_word_out;
      (q.st == DBT_S_DAT && is_out && !ch) |=> (io_wdata == $past(mem_rdata));
   endproperty
   a_word_out: assert property (p_word_out) else $error("word not sent whole");

   property p_advance;
      (q.st == DBT_S_WB && q.adv && nxt != q.last_addr)
         |=> (mem_we && mem_wdata == $past(q.cur_addr) + 16'h0001);
   endproperty
   a_advance: assert property (p_advance) else $error("position not advanced");

   sequence s_last_word;
      q.st == DBT_S_WB && q.adv && nxt == q.last_addr;
   endsequence
   property p_complete;
      s_last_word |=> macro_irq && q.done;
   endproperty
   a_complete: assert property (p_complete) else $error("no interrupt at end");

   sequence s_io_fail;
      q.st == DBT_S_IO && io_ack && io_err;
   endsequence
   property p_error;
      s_io_fail |=> macro_irq && q.err && q.st == DBT_S_IDLE;
   endproperty
   a_error: assert property (p_error) else $error("no interrupt on error");

   property p_flag;
      (s_last_word and (q.kind == DBT_K_MULTI))
         |-> ##3 (mem_we && mem_lock && mem_wdata[$past(q.sta[3:0], 3)]);
   endproperty
   a_flag: assert property (p_flag) else $error("termination flag not set");

   property p_clk_count;
      (q.st == DBT_S_CW3 && q.kind == DBT_K_SINGLE)
         |=> (mem_we && mem_wdata == $past(q.clkcnt) + 16'h0001);
   endproperty
   a_clk_count: assert property (p_clk_count) else $error("clock count not bumped");

   property p_clk_irq;
      clk_irq |-> $past(q.ctrl[`DBT_CTRL_CLKIE]) && $past(q.clkcnt) + 16'h0001 == mem_wdata
                  && $past(q.clkcnt + 16'h0001 == mem_rdata);
   endproperty
   a_clk_irq: assert property (p_clk_irq) else $error("clock interrupt without match");
endmodule

/* File: dbt_engine_bench.sv */
`include "dbt_map.svh"
module dbt_engine_bench
   import dbt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, svc_req = 0, svc_top = 0;
   logic instr_done = 0, mem_re, mem_we, mem_lock, io_req, io_write, io_ack, io_err;
   logic macro_irq, clk_irq, err_on = 0;
   logic [3:0]  reg_addr = 4'h0, io_equip;
   logic [4:0]  svc_station = 5'h00;
   logic [6:0]  io_station;
   logic [7:0]  io_cnt, n0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, mem_addr, mem_wdata, mem_rdata;
   logic [15:0] io_wdata, io_rdata, in_data = 16'hBEEF, v;
   int          fail_count = 0, check_count = 0, i;
   always #5 ref_clk = ~ref_clk;
   dbt_engine #(.TICK_CYCLES(19'd20)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .svc_req(svc_req), .svc_top(svc_top),
      .instr_done(instr_done), .svc_station(svc_station), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_re(mem_re), .mem_we(mem_we), .mem_lock(mem_lock),
      .mem_rdata(mem_rdata), .io_req(io_req), .io_write(io_write), .io_equip(io_equip),
      .io_station(io_station), .io_wdata(io_wdata), .io_ack(io_ack), .io_err(io_err),
      .io_rdata(io_rdata), .macro_irq(macro_irq), .clk_irq(clk_irq));
   dbt_partner P (.ref_clk(ref_clk), .rst_n(rst_n), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_re(mem_re), .mem_we(mem_we), .mem_rdata(mem_rdata),
      .io_req(io_req), .io_ack(io_ack), .io_err(io_err), .io_rdata(io_rdata),
      .err_on(err_on), .in_data(in_data), .io_cnt(io_cnt));
   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Table at 0x10, fourth word zero as software must leave it
   task automatic ent(input logic [15:0] w1, input logic [15:0] cur, input logic [15:0] last);
      P.mem[16] = w1;
      P.mem[17] = cur;
      P.mem[18] = last;
      P.mem[19] = 16'h0000;
      wr(`DBT_REG_BASE, 16'h0010);
   endtask
   // One service event; a missing expected interrupt ends the run
   task automatic svc(input logic top, input logic exp);
      logic seen;
      seen = 1'b0;
      n0 = io_cnt;
      @(posedge ref_clk);
      svc_req <= 1'b1;
      svc_top <= top;
      instr_done <= 1'b1;
      @(posedge ref_clk);
      {svc_req, svc_top, instr_done} <= 3'h0;
      for (i = 0; i < 60; i++) begin
         @(posedge ref_clk);
         #1 if (macro_irq === 1'b1) seen = 1'b1;
      end
      chk(seen, exp);
      if (exp && !seen) finish_test();
   endtask
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_word_out();
      ent(16'h0AA1, 16'h001F, 16'h0020);
      P.mem[32] = 16'h1234;
      wr(`DBT_REG_CTRL, 16'h0001);
      svc(1'b0, 1'b0);
      chk(io_cnt, n0);
      svc(1'b1, 1'b1);
      chk({io_write, io_equip, io_station}, {4'h0, 1'b1, 4'h5, 7'h21});
      chk(io_wdata, 16'h1234);
      chk(P.mem[17], 16'h0020);
      rd(`DBT_REG_STAT, v);
      chk(v[0], 1'b1);
      svc(1'b1, 1'b0);
      chk(io_cnt, n0);
   endtask
   task automatic t_word_in();
      ent(16'h02A1, 16'h002F, 16'h0031);
      svc(1'b1, 1'b0);
      chk(io_write, 1'b0);
      chk(P.mem[48], 16'hBEEF);
      chk(P.mem[17], 16'h0030);
   endtask
   task automatic t_char_out();
      ent(16'h2AA1, 16'h005F, 16'h0060);
      P.mem[96] = 16'hC3A5;
      svc(1'b1, 1'b0);
      chk(io_wdata[7:0], 8'hC3);
      chk(P.mem[17], 16'h005F);
      svc(1'b1, 1'b1);
      chk(io_wdata[7:0], 8'hA5);
      chk(P.mem[17], 16'h0060);
   endtask
   task automatic t_error();
      ent(16'h0AA1, 16'h001F, 16'h0020);
      err_on <= 1'b1;
      svc(1'b1, 1'b1);
      err_on <= 1'b0;
      rd(`DBT_REG_STAT, v);
      chk(v[1], 1'b1);
      chk(P.mem[17], 16'h001F);
      rd(4'hF, v);
      chk(v, 16'h0000);
   endtask
   // Multi table: station 1 entry at 0x18; port table: position 1 at 0x14
   task automatic t_tables();
      ent(16'h4006, 16'h0000, 16'h0000);
      P.mem[24] = 16'h4AA1;
      P.mem[25] = 16'h002F;
      P.mem[26] = 16'h0030;
      svc_station <= 5'h01;
      svc(1'b1, 1'b1);
      chk(io_wdata, 16'hBEEF);
      chk(P.mem[25], 16'h0030);
      chk(P.mem[17], 16'h0002);
      P.mem[17] = 16'h0000;
      ent(16'h8C04, 16'h0000, 16'h0000);
      P.mem[20] = 16'h8C04;
      P.mem[21] = 16'h002F;
      P.mem[22] = 16'h0030;
      svc(1'b1, 1'b1);
      chk({io_equip, io_station}, {4'h8, 7'h01});
      chk(P.mem[21], 16'h0030);
      svc_station <= 5'h02;
      svc(1'b1, 1'b0);
      chk(io_cnt, n0);
   endtask
   task automatic t_clock();
      P.mem[65] = 16'h0000;
      P.mem[66] = 16'h0003;
      wr(`DBT_REG_CBASE, 16'h0040);
      wr(`DBT_REG_CTRL, 16'h0007);
      for (i = 0; i < 200 && clk_irq !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      if (clk_irq !== 1'b1) begin
         fail_count++;
         finish_test();
      end
      chk(i >= 50, 1'b1);
      @(posedge ref_clk);
      #1 chk(P.mem[65], 16'h0003);
      rd(`DBT_REG_STAT, v);
      chk(v[2], 1'b1);
      P.mem[66] = 16'h0006;
      repeat (19) @(posedge ref_clk);
      #1 chk(P.mem[65], 16'h0004);
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(`DBT_REG_CTRL, v);
      chk(v, 16'h0000);
      t_word_out();
      t_word_in();
      t_char_out();
      t_error();
      t_tables();
      t_clock();
      finish_test();
   end
endmodule

/* File: dbt_map.svh */
`ifndef DBT_MAP_SVH
`define DBT_MAP_SVH

// -----------------------------------------------------------------
// Register port
// -----------------------------------------------------------------
`define DBT_REG_CTRL     4'h0
`define DBT_REG_BASE     4'h1
`define DBT_REG_CBASE    4'h2
`define DBT_REG_STAT     4'h3
`define DBT_CTRL_ARM     0
`define DBT_CTRL_CLKEN   1
`define DBT_CTRL_CLKIE   2
`define DBT_CTRL_RST     3'h0
`define DBT_STAT_DONE    0
`define DBT_STAT_ERR     1
`define DBT_STAT_CHIT    2
`define DBT_STAT_BUSY    3

// -----------------------------------------------------------------
// Table layout
// -----------------------------------------------------------------
`define DBT_W1_PORT      15
`define DBT_W1_MULTI     14
`define DBT_W1_CHAR      13
`define DBT_W1_DIR       11
`define DBT_W1_EQ_HI     10
`define DBT_W1_EQ_LO     7
`define DBT_W1_ST_HI     6
`define DBT_MAXST_HI     6
`define DBT_MAXPOS_HI    4
`define DBT_MAX_LO       2
`define DBT_OFS_CUR      16'h0001
`define DBT_OFS_LAST     16'h0002
`define DBT_OFS_FLAG     16'h0001
`define DBT_ENTRY_WORDS  16'h0004

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define DBT_CLK_HZ       100000000
`define DBT_TICK_MS_NUM  10
`define DBT_TICK_MS_DEN  3
`define DBT_TICK_CYCLES  ((`DBT_TICK_MS_NUM * `DBT_CLK_HZ) / (`DBT_TICK_MS_DEN * 1000))
`endif

/* File: dbt_partner.sv */
module dbt_partner
   import dbt_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   input  wire logic        mem_re,
   input  wire logic        mem_we,
   output logic      [15:0] mem_rdata,
   input  wire logic        io_req,
   output logic             io_ack,
   output logic             io_err,
   output logic      [15:0] io_rdata,
   input  wire logic        err_on,
   input  wire logic [15:0] in_data,
   output logic      [7:0]  io_cnt
);
   logic [15:0] mem [0:255];
   logic [1:0]  dly;
   logic        busy;
   // Answer in the strobe's own cycle, where the engine samples it;
   // idle bus shows the inverse word, never good data
   assign mem_rdata = mem_re ? mem[mem_addr[7:0]] : ~mem[mem_addr[7:0]];
   // Plain process: the bench preloads tables into the same array
   always @(posedge ref_clk) begin
      if (mem_we) begin
         mem[mem_addr[7:0]] <= mem_wdata;
      end
   end
   always_ff @(posedge ref_clk) begin
      io_rdata  <= ~io_rdata;
      io_ack    <= 1'b0;
      io_err    <= 1'b0;
      if (!rst_n) begin
         busy      <= 1'b0;
         io_cnt    <= 8'h00;
         io_rdata  <= 16'h0000;
      end else if (io_req) begin
         busy   <= 1'b1;
         dly    <= 2'h2;
         io_cnt <= io_cnt + 8'h01;
      end else if (busy && dly == 2'h0) begin
         busy     <= 1'b0;
         io_ack   <= 1'b1;
         io_err   <= err_on;
         io_rdata <= in_data;
      end else if (busy) begin
         dly <= dly - 2'h1;
      end
   end
endmodule

/* File: dbt_pkg.sv */
`include "dbt_map.svh"
package dbt_pkg;
   typedef enum logic [3:0] {
      DBT_S_IDLE = 4'h0,
      DBT_S_HDR  = 4'h1,
      DBT_S_W1   = 4'h3,
      DBT_S_W2   = 4'h2,
      DBT_S_W3   = 4'h6,
      DBT_S_DAT  = 4'h7,
      DBT_S_IO   = 4'h5,
      DBT_S_WB   = 4'h4,
      DBT_S_FLR  = 4'hC,
      DBT_S_CW2  = 4'h8,
      DBT_S_CW3  = 4'h9
   } dbt_state_t;

   typedef enum logic [1:0] {
      DBT_K_SINGLE = 2'h0,
      DBT_K_MULTI  = 2'h1,
      DBT_K_PORT   = 2'h2
   } dbt_kind_t;

   typedef struct packed {
      dbt_state_t  st;
      dbt_kind_t   kind;
      logic [15:0] w1;
      logic [15:0] cur_addr;
      logic [15:0] last_addr;
      logic [15:0] dat;
      logic [15:0] ent;
      logic [15:0] base;
      logic [15:0] cbase;
      logic [15:0] clkcnt;
      logic [4:0]  sta;
      logic [2:0]  ctrl;
      logic        done;
      logic        err;
      logic        chit;
      logic        tick_pend;
      logic        adv;
      logic [31:0] phase;
      logic [15:0] mem_addr;
      logic [15:0] mem_wdata;
      logic        mem_re;
      logic        mem_we;
      logic        mem_lock;
      logic        io_req;
      logic        io_write;
      logic [3:0]  io_equip;
      logic [6:0]  io_station;
      logic [15:0] io_wdata;
      logic        macro_irq;
      logic        clk_irq;
      logic [15:0] rdata;
   } dbt_core_t;

   typedef struct packed {
      logic [18:0] cnt;
      logic        tick;
   } dbt_tick_st_t;
endpackage

/* File: dbt_tick_gen.sv */
`include "dbt_map.svh"
module dbt_tick_gen
   import dbt_pkg::*;
#(
   parameter logic [18:0] TICK_CYCLES = 19'(`DBT_TICK_CYCLES)
) (
   input  wire logic   ref_clk,
   input  wire logic   rst_n,
   dbt_tick_if.gen     tk
);
   dbt_tick_st_t q;
   dbt_tick_st_t d;

   // Held at zero while disabled so the first tick is a full period away
   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (!tk.en) begin
         d.cnt = 19'h00000;
      end else if (q.cnt >= TICK_CYCLES - 19'h00001) begin
         d.cnt = 19'h00000;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + 19'h00001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tk.tick = q.tick;
endmodule

/* File: dbt_tick_if.sv */
interface dbt_tick_if;
   logic en;
   logic tick;
   modport gen (input en, output tick);
   modport host (output en, input tick);
endinterface
